// ===== rtl/sfu_pkg.sv
// Purpose: shared constants for the scalar arithmetic functional units
// Assumes: 64-bit words, float = sign 63, exponent 62:48, coefficient 47:0
// Notes:   opcodes are the three leading octal digits as a 7-bit code
package sfu_pkg;
  // scalar opcodes handled here
  localparam logic [6:0] OP_IADD  = 7'h30;
  localparam logic [6:0] OP_ISUB  = 7'h31;
  localparam logic [6:0] OP_FADD  = 7'h32;
  localparam logic [6:0] OP_FSUB  = 7'h33;
  localparam logic [6:0] OP_FMUL  = 7'h34;
  localparam logic [6:0] OP_FMULH = 7'h35;
  localparam logic [6:0] OP_FMULR = 7'h36;
  localparam logic [6:0] OP_RECIT = 7'h37;
  localparam logic [6:0] OP_RECIP = 7'h38;
  localparam logic [6:0] OP_XMIT  = 7'h39;
  // vector opcodes that occupy shared units
  localparam logic [6:0] VOP_FADD_LO = 7'h78;
  localparam logic [6:0] VOP_FADD_HI = 7'h7b;
  localparam logic [6:0] VOP_FMUL_LO = 7'h70;
  localparam logic [6:0] VOP_FMUL_HI = 7'h77;
  localparam logic [6:0] VOP_LOG_LO  = 7'h60;
  localparam logic [6:0] VOP_LOG_HI  = 7'h65;
  localparam logic [6:0] VOP_RECIP   = 7'h7c;
  // result latencies in clock periods after issue
  localparam logic [3:0] LAT_IADD  = 4'h3;
  localparam logic [3:0] LAT_FADD  = 4'h6;
  localparam logic [3:0] LAT_FMUL  = 4'h7;
  localparam logic [3:0] LAT_RECIP = 4'he;
  localparam logic [3:0] LAT_XMIT  = 4'h2;
  localparam int         SLOTS     = 14;
  localparam logic [7:0] BUSY_EXTRA = 8'h04;
  localparam int         NUNITS    = 4;
  // float layout
  localparam int          COEF_W   = 48;
  localparam int          EXP_W    = 15;
  localparam logic [14:0] EXP_BIAS = 15'h4000;
  localparam logic [14:0] XMIT_EXP = 15'h4030;
  localparam logic [63:0] SIGN_ONLY = 64'h8000_0000_0000_0000;
  localparam logic [63:0] MASK_HALF = 64'hffff_ffff_fff8_0000;
  localparam logic [63:0] MASK_RCP  = 64'hffff_ffff_fffc_0000;
  localparam logic [47:0] RND_HALF  = 48'h0000_0004_0000;
  localparam logic [47:0] COEF_TOP  = 48'h8000_0000_0000;
  // constants loaded by the transmit opcode, j = 3..7
  localparam logic [63:0] K_J3 = 64'h4030_c000_0000_0000;
  localparam logic [63:0] K_J4 = 64'h4000_8000_0000_0000;
  localparam logic [63:0] K_J5 = 64'h4001_8000_0000_0000;
  localparam logic [63:0] K_J6 = 64'h4002_8000_0000_0000;
  localparam logic [63:0] K_J7 = 64'h4003_8000_0000_0000;
  localparam logic [23:0] AK_ZERO_VAL = 24'h00_0001;
endpackage

// ===== rtl/sfu_busy.sv
// Purpose: busy window of a unit shared with vector instructions
// Assumes: start is a one-cycle pulse from issue logic on the same clock
// Notes:   busy for vector length plus four cycles after start
module sfu_busy (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       nrst,
  // vector start
  input  wire logic       start,
  input  wire logic [6:0] vector_length_count,
  // status
  output logic            busy
);
  typedef struct packed {
    logic [7:0] cnt;
  } sfu_busy_t;

  sfu_busy_t st_r;
  sfu_busy_t st_nxt;

  // a restart reloads the full window
  always_comb begin
    st_nxt = st_r;
    if (start) begin
      st_nxt.cnt = {1'b0, vector_length_count} + sfu_pkg::BUSY_EXTRA;
    end else if (st_r.cnt != 8'h00) begin
      st_nxt.cnt = st_r.cnt - 8'h01;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign busy = (st_r.cnt != 8'h00);
endmodule

// ===== rtl/sfu_fpnorm.sv
// Purpose: normalise a sign, exponent and coefficient with carry bit
// Assumes: coefficient carries one overflow bit above bit 47
// Notes:   combinational; a zero coefficient yields an all-zero word
module sfu_fpnorm (
  // unnormalised input
  input  wire logic        sign,
  input  wire logic [14:0] expo,
  input  wire logic [48:0] coef,
  // normalised word
  output logic      [63:0] word
);
  logic [47:0] c;
  logic [14:0] e;
  logic [5:0]  lz;
  logic        found;

  // carry out first, then shift left until bit 47 is set
  always_comb begin
    c     = coef[48] ? coef[48:1] : coef[47:0];
    e     = coef[48] ? expo + 15'h0001 : expo;
    lz    = '0;
    found = 1'b0;
    for (int b = sfu_pkg::COEF_W - 1; b >= 0; b--) begin
      if (!found && c[b]) begin
        found = 1'b1;
        lz    = 6'(sfu_pkg::COEF_W - 1 - b);
      end
    end
    if (c == '0) begin
      word = '0;
    end else begin
      word = {sign, 15'(e - {9'h000, lz}), c << lz};
    end
  end
endmodule

// ===== rtl/sfu_core.sv
// Purpose: scalar integer add, float add, float multiply, reciprocal and
//          address-to-scalar transmit units with issue hold and write-back
// Assumes: operands arrive with the issue request; reservations come from
//          the scoreboard on the same clock
// Notes:   one result port; issue also holds when its write slot is taken
//
// Contract
// - opcode 060 writes the 64-bit integer sum, no overflow flag.
// - opcode 061 writes first minus second, no overflow flag.
// - integer add and subtract deliver 3 cycles after issue.
// - j zero gives zero, k zero gives only bit 63 for add unit.
// - float add 062/063 always writes a normalized result.
// - float add treats negative zero as an all-zero word.
// - float add held while vector 170-173 busy, length plus 4.
// - float add issues in one cycle, result 6 cycles after.
// - multiply unit runs 064-067, no forced normalisation.
// - opcode 065 rounds half precision and clears low 19 bits.
// - opcode 067 computes two minus the product.
// - multiply held while vector 160-167 or 140-145 busy.
// - multiply issues in one cycle, result 7 cycles after.
// - both exponents zero gives upper 48 bits of 96-bit product.
// - reciprocal keeps 30 significant bits, low 18 bits cleared.
// - reciprocal delivers after 14 cycles, held while 174 busy.
// - reciprocal assumes bit 47 set; zero input flags range error.
// - transmit j=0 zero-extends the 24-bit address value.
// - transmit j=1 sign-extends the 24-bit address value.
// - transmit j=2 builds float with exponent 40060 octal.
// - negative address gives magnitude coefficient and sign bit 63.
// - j=3..7 load constants 0.75*2^48, 0.5, 1.0, 2.0, 4.0.
// - transmit held on reserved address source, result after 2.
// - j=3 constant has exponent 40060 and coefficient 6000 octal.
module sfu_core (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // issue request
  input  wire logic        iss_valid,
  input  wire logic [6:0]  iss_op,
  input  wire logic [2:0]  iss_i,
  input  wire logic [2:0]  iss_j,
  input  wire logic [2:0]  iss_k,
  output logic             iss_ready,
  // operands
  input  wire logic [63:0] scalar_src_first,
  input  wire logic [63:0] scalar_src_second,
  input  wire logic [23:0] address_src_reg,
  // scoreboard
  input  wire logic [7:0]  sreg_resv,
  input  wire logic [7:0]  areg_resv,
  // vector unit occupancy
  input  wire logic        vec_issue,
  input  wire logic [6:0]  vec_op,
  input  wire logic [6:0]  vector_length_count,
  // result write-back
  output logic             res_valid,
  output logic [2:0]       res_idx,
  output logic [63:0]      res_data,
  output logic             range_err
);
  typedef struct packed {
    logic        vld;
    logic [2:0]  idx;
    logic        rerr;
    logic [63:0] data;
  } sfu_slot_t;

  typedef struct packed {
    sfu_slot_t [sfu_pkg::SLOTS-1:0] slot;
  } sfu_state_t;

  typedef struct packed {
    logic        sign;
    logic [14:0] expo;
    logic [48:0] coef;
  } sfu_pre_t;

  sfu_state_t st_r;
  sfu_state_t st_nxt;

  // latency per opcode; zero marks an opcode this block does not run
  function automatic logic [3:0] lat_of(input logic [6:0] op);
    unique case (op)
      sfu_pkg::OP_IADD, sfu_pkg::OP_ISUB:   lat_of = sfu_pkg::LAT_IADD;
      sfu_pkg::OP_FADD, sfu_pkg::OP_FSUB:   lat_of = sfu_pkg::LAT_FADD;
      sfu_pkg::OP_FMUL, sfu_pkg::OP_FMULH,
      sfu_pkg::OP_FMULR, sfu_pkg::OP_RECIT: lat_of = sfu_pkg::LAT_FMUL;
      sfu_pkg::OP_RECIP:                    lat_of = sfu_pkg::LAT_RECIP;
      sfu_pkg::OP_XMIT:                     lat_of = sfu_pkg::LAT_XMIT;
      default:                              lat_of = 4'h0;
    endcase
  endfunction

  // align and add two floats; negative zero counts as plain zero
  function automatic sfu_pre_t fadd_pre(input logic [63:0] a_in,
                                        input logic [63:0] b_in);
    logic [63:0] a;
    logic [63:0] b;
    logic [63:0] big;
    logic [63:0] sml;
    logic [14:0] diff;
    logic [47:0] cs;
    sfu_pre_t    r;
    a = (a_in[62:0] == '0) ? 64'h0 : a_in;
    b = (b_in[62:0] == '0) ? 64'h0 : b_in;
    if (a[62:48] >= b[62:48]) begin
      big = a;
      sml = b;
    end else begin
      big = b;
      sml = a;
    end
    diff = big[62:48] - sml[62:48];
    cs   = (diff >= 15'(sfu_pkg::COEF_W)) ? 48'h0 : sml[47:0] >> diff;
    r.expo = big[62:48];
    if (big[63] == sml[63]) begin
      r.sign = big[63];
      r.coef = {1'b0, big[47:0]} + {1'b0, cs};
    end else if (big[47:0] >= cs) begin
      r.sign = big[63];
      r.coef = {1'b0, big[47:0] - cs};
    end else begin
      r.sign = sml[63];
      r.coef = {1'b0, cs - big[47:0]};
    end
    return r;
  endfunction

  // operand selection shared by add and multiply units
  logic [63:0] opa;
  logic [63:0] opb;
  assign opa = (iss_j == 3'h0) ? 64'h0 : scalar_src_first;
  assign opb = (iss_k == 3'h0) ? sfu_pkg::SIGN_ONLY
                               : scalar_src_second;

  // float add unit front end, normaliser after it
  sfu_pre_t    fa_pre;
  logic [63:0] fa_word;
  assign fa_pre = fadd_pre(opa, (iss_op == sfu_pkg::OP_FSUB)
                                ? {~opb[63], opb[62:0]} : opb);
  sfu_fpnorm u_fadd_norm (
    .sign (fa_pre.sign),
    .expo (fa_pre.expo),
    .coef (fa_pre.coef),
    .word (fa_word)
  );

  // multiply unit; not renormalised for unnormalised operands
  logic [95:0] prod;
  logic [47:0] mcoef;
  logic [48:0] mrnd;
  logic [14:0] mexp;
  logic        mrbit;
  logic [63:0] mul_word;
  always_comb begin
    prod  = opa[47:0] * opb[47:0];
    mexp  = 15'(opa[62:48] + opb[62:48] - sfu_pkg::EXP_BIAS);
    mcoef = prod[95] ? prod[95:48] : prod[94:47];
    mrbit = prod[95] ? prod[47] : prod[46];
    if (!prod[95]) begin
      mexp = mexp - 15'h0001;
    end
    unique case (iss_op)
      sfu_pkg::OP_FMULR: mrnd = {1'b0, mcoef} + {48'h0, mrbit};
      sfu_pkg::OP_FMULH: mrnd = {1'b0, mcoef} + {1'b0, sfu_pkg::RND_HALF};
      default:           mrnd = {1'b0, mcoef};
    endcase
    if (mrnd[48]) begin
      mrnd = {1'b0, sfu_pkg::COEF_TOP};
      mexp = mexp + 15'h0001;
    end
    if (opa[62:48] == '0 && opb[62:48] == '0) begin
      mul_word = {16'h0000, prod[95:48]};
    end else begin
      mul_word = {opa[63] ^ opb[63], mexp, mrnd[47:0]};
    end
    if (iss_op == sfu_pkg::OP_FMULH) begin
      mul_word = mul_word & sfu_pkg::MASK_HALF;
    end
  end

  // reciprocal iteration: 2.0 minus the product through the add path
  sfu_pre_t    ri_pre;
  logic [63:0] ri_word;
  assign ri_pre = fadd_pre(sfu_pkg::K_J6,
                           {~mul_word[63], mul_word[62:0]});
  sfu_fpnorm u_recit_norm (
    .sign (ri_pre.sign),
    .expo (ri_pre.expo),
    .coef (ri_pre.coef),
    .word (ri_word)
  );

  // reciprocal approximation; divisor bit 47 forced, never tested
  logic [47:0] rdiv;
  logic [95:0] rq;
  logic [63:0] rcp_word;
  logic [14:0] rexp;
  always_comb begin
    rdiv = {1'b1, opa[46:0]};
    rq   = {1'b1, 95'h0} / {48'h0, rdiv};
    rexp = 15'({sfu_pkg::EXP_BIAS, 1'b0} - {1'b0, opa[62:48]} + 16'h0001);
    if (rq[48]) begin
      rcp_word = {opa[63], rexp + 15'h0001, sfu_pkg::COEF_TOP};
    end else begin
      rcp_word = {opa[63], rexp, rq[47:0]};
    end
    rcp_word = rcp_word & sfu_pkg::MASK_RCP;
  end

  // address transmit and constant generator
  logic [23:0] akv;
  logic [23:0] akmag;
  logic [63:0] xm_word;
  always_comb begin
    akv   = (iss_k == 3'h0) ? sfu_pkg::AK_ZERO_VAL : address_src_reg;
    akmag = akv[23] ? 24'(-akv) : akv;
    unique case (iss_j)
      3'h0: xm_word = {40'h0, akv};
      3'h1: xm_word = {{40{akv[23]}}, akv};
      3'h2: xm_word = {akv[23], sfu_pkg::XMIT_EXP, 24'h0, akmag};
      3'h3: xm_word = sfu_pkg::K_J3;
      3'h4: xm_word = sfu_pkg::K_J4;
      3'h5: xm_word = sfu_pkg::K_J5;
      3'h6: xm_word = sfu_pkg::K_J6;
      3'h7: xm_word = sfu_pkg::K_J7;
    endcase
  end

  // vector occupancy of shared units: fadd, fmul, logical 2, recip
  logic [sfu_pkg::NUNITS-1:0] ustart;
  logic [sfu_pkg::NUNITS-1:0] ubusy;
  assign ustart[0] = vec_issue && vec_op >= sfu_pkg::VOP_FADD_LO
                     && vec_op <= sfu_pkg::VOP_FADD_HI;
  assign ustart[1] = vec_issue && vec_op >= sfu_pkg::VOP_FMUL_LO
                     && vec_op <= sfu_pkg::VOP_FMUL_HI;
  assign ustart[2] = vec_issue && vec_op >= sfu_pkg::VOP_LOG_LO
                     && vec_op <= sfu_pkg::VOP_LOG_HI;
  assign ustart[3] = vec_issue && vec_op == sfu_pkg::VOP_RECIP;
  for (genvar u = 0; u < sfu_pkg::NUNITS; u++) begin : g_busy
    sfu_busy u_busy (
      .clk                 (clk),
      .nrst                (nrst),
      .start               (ustart[u]),
      .vector_length_count (vector_length_count),
      .busy                (ubusy[u])
    );
  end

  // issue hold decision
  logic [3:0] lat;
  logic       is_iadd;
  logic       is_fadd;
  logic       is_fmul;
  logic       is_rcp;
  logic       is_xm;
  logic       hold;
  logic       accept;
  logic [63:0] result;
  always_comb begin
    lat     = lat_of(iss_op);
    is_iadd = (lat == sfu_pkg::LAT_IADD);
    is_fadd = (lat == sfu_pkg::LAT_FADD);
    is_fmul = (lat == sfu_pkg::LAT_FMUL);
    is_rcp  = (lat == sfu_pkg::LAT_RECIP);
    is_xm   = (lat == sfu_pkg::LAT_XMIT);
    hold    = sreg_resv[iss_i];
    if (!is_xm && iss_j != 3'h0 && sreg_resv[iss_j]) begin
      hold = 1'b1;
    end
    if (!is_xm && !is_rcp && iss_k != 3'h0 && sreg_resv[iss_k]) begin
      hold = 1'b1;
    end
    if (is_xm && iss_k != 3'h0 && areg_resv[iss_k]) begin
      hold = 1'b1;
    end
    if ((is_fadd && ubusy[0]) || (is_rcp && ubusy[3])) begin
      hold = 1'b1;
    end
    if (is_fmul && (ubusy[1] || ubusy[2])) begin
      hold = 1'b1;
    end
    // write slot already claimed by a longer-latency result
    if (lat < 4'(sfu_pkg::SLOTS) && st_r.slot[lat].vld) begin
      hold = 1'b1;
    end
    iss_ready = (lat != 4'h0) && !hold;
    accept    = iss_valid && iss_ready;
    unique case (1'b1)
      is_iadd: result = (iss_op == sfu_pkg::OP_ISUB) ? opa - opb
                                                     : opa + opb;
      is_fadd: result = fa_word;
      is_fmul: result = (iss_op == sfu_pkg::OP_RECIT) ? ri_word
                                                      : mul_word;
      is_rcp:  result = rcp_word;
      default: result = xm_word;
    endcase
  end

  // write-back delay line; slot 0 drives the result port
  always_comb begin
    st_nxt = st_r;
    for (int s = 0; s < sfu_pkg::SLOTS - 1; s++) begin
      st_nxt.slot[s] = st_r.slot[s+1];
    end
    st_nxt.slot[sfu_pkg::SLOTS-1] = '0;
    for (int s = 0; s < sfu_pkg::SLOTS; s++) begin
      if (accept && 4'(s + 1) == lat) begin
        st_nxt.slot[s].vld  = 1'b1;
        st_nxt.slot[s].idx  = iss_i;
        st_nxt.slot[s].rerr = is_rcp && opa == 64'h0;
        st_nxt.slot[s].data = result;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign res_valid = st_r.slot[0].vld;
  assign res_idx   = st_r.slot[0].idx;
  assign res_data  = st_r.slot[0].data;
  assign range_err = st_r.slot[0].vld && st_r.slot[0].rerr;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_iadd_lat: assert property (iss_valid && iss_ready && is_iadd
    |-> ##3 res_valid && res_idx == $past(iss_i, 3))
    else $error("integer add result not at 3 cycles");
  a_fadd_lat: assert property (iss_valid && iss_ready && is_fadd
    |-> ##6 res_valid && res_idx == $past(iss_i, 6))
    else $error("float add result not at 6 cycles");
  a_fmul_lat: assert property (iss_valid && iss_ready && is_fmul
    |-> ##7 res_valid && res_idx == $past(iss_i, 7))
    else $error("multiply result not at 7 cycles");
  a_rcp_low: assert property (iss_valid && iss_ready && is_rcp
    |-> ##14 res_valid && res_data[17:0] == 18'h0_0000)
    else $error("reciprocal low bits not clear at 14 cycles");
  a_half_low: assert property (iss_valid && iss_ready
    && iss_op == sfu_pkg::OP_FMULH
    |-> ##7 res_valid && res_data[18:0] == 19'h0_0000)
    else $error("half product low bits not clear");
  a_xmit_zext: assert property (iss_valid && iss_ready && is_xm
    && iss_j == 3'h0 |-> ##2 res_valid && res_data[63:24] == '0)
    else $error("unsigned transmit upper bits not zero");
  a_dest_hold: assert property (sreg_resv[iss_i] |-> !iss_ready)
    else $error("issued with destination reserved");
  a_fadd_vbusy: assert property (ustart[0] ##1 is_fadd
    |-> !iss_ready)
    else $error("float add issued while vector add busy");
  a_xmit_ahold: assert property (is_xm && iss_k != 3'h0
    && areg_resv[iss_k] |-> !iss_ready)
    else $error("transmit issued with address source reserved");
endmodule

// ===== test/sfu_regs_model.sv
// Purpose: scalar register file and reservation board beside the units
// Assumes: reservation set on the edge that takes an issue request
// Notes:   bench preloads registers by hierarchical write before issue
module sfu_regs_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // accepted issue
  input  wire logic        take,
  input  wire logic [2:0]  iss_i,
  input  wire logic [2:0]  iss_j,
  input  wire logic [2:0]  iss_k,
  // write-back
  input  wire logic        res_valid,
  input  wire logic [2:0]  res_idx,
  input  wire logic [63:0] res_data,
  // operands and reservations
  output logic      [63:0] scalar_src_first,
  output logic      [63:0] scalar_src_second,
  output logic      [7:0]  sreg_resv
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [63:0] sreg [8];
  // operands read straight from the file, no bypass path
  assign scalar_src_first  = sreg[iss_j];
  assign scalar_src_second = sreg[iss_k];
  // set wins over clear so a chained write stays guarded
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sreg_resv <= 8'h00;
    end else begin
      if (res_valid) begin
        sreg[res_idx]      <= res_data;
        sreg_resv[res_idx] <= 1'b0;
      end
      if (take) begin
        sreg_resv[iss_i] <= 1'b1;
      end
    end
  end
endmodule

// ===== test/sfu_core_tb_top.sv
// Purpose: self-checking bench for the scalar arithmetic units
// Assumes: result checked in the cycle that res_valid stands
// Notes:   rows hold operand pool indices and the expected word
module sfu_core_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    logic [6:0]  op;
    logic [2:0]  j;
    logic [2:0]  k;
    logic [3:0]  a;
    logic [3:0]  b;
    logic [63:0] ex;
  } sfu_row_t;
  logic        clk, nrst, iss_valid, iss_ready, vec_issue, take;
  logic [6:0]  iss_op, vec_op, vector_length_count;
  logic [2:0]  iss_i, iss_j, iss_k, res_idx;
  logic [63:0] scalar_src_first, scalar_src_second, res_data;
  logic [23:0] address_src_reg;
  logic [7:0]  sreg_resv, areg_resv;
  logic        res_valid, range_err, rerr;
  int          num_errors, comparisons, n;
  // operand pool: floats, integers and address values
  logic [63:0] pool [16] = '{64'h0, 64'h4001_8000_0000_0000,
    64'h4002_8000_0000_0000, 64'h4000_8000_0000_0000,
    64'h8000_0000_0000_0000, 64'h5, 64'h7, '1, 64'h1,
    64'h4002_4000_0000_0000, 64'h4001_8000_0000_ffff,
    64'h0100_0000, 64'h4000_0000, 64'h0080_0001, 64'h00ff_fffb,
    64'hc002_8000_0000_0000};
  sfu_row_t rows [27] = '{
    '{7'h30, 3'h1, 3'h2, 4'h5, 4'h6, 64'h0000_0000_0000_000c},
    '{7'h30, 3'h1, 3'h2, 4'h7, 4'h8, 64'h0000_0000_0000_0000},
    '{7'h31, 3'h1, 3'h2, 4'h5, 4'h6, 64'hffff_ffff_ffff_fffe},
    '{7'h31, 3'h0, 3'h2, 4'h0, 4'h8, 64'hffff_ffff_ffff_ffff},
    '{7'h30, 3'h0, 3'h0, 4'h0, 4'h0, 64'h8000_0000_0000_0000},
    '{7'h31, 3'h1, 3'h0, 4'h5, 4'h0, 64'h8000_0000_0000_0005},
    '{7'h32, 3'h1, 3'h2, 4'h1, 4'h1, 64'h4002_8000_0000_0000},
    '{7'h32, 3'h1, 3'h2, 4'h9, 4'h0, 64'h4001_8000_0000_0000},
    '{7'h32, 3'h1, 3'h2, 4'h4, 4'h1, 64'h4001_8000_0000_0000},
    '{7'h33, 3'h1, 3'h2, 4'h2, 4'h1, 64'h4001_8000_0000_0000},
    '{7'h34, 3'h1, 3'h2, 4'h2, 4'h2, 64'h4003_8000_0000_0000},
    '{7'h34, 3'h1, 3'h2, 4'ha, 4'h1, 64'h4001_8000_0000_ffff},
    '{7'h35, 3'h1, 3'h2, 4'ha, 4'h1, 64'h4001_8000_0000_0000},
    '{7'h36, 3'h1, 3'h2, 4'h2, 4'h3, 64'h4001_8000_0000_0000},
    '{7'h37, 3'h1, 3'h2, 4'h3, 4'h1, 64'h4001_c000_0000_0000},
    '{7'h34, 3'h1, 3'h2, 4'hb, 4'hc, 64'h0000_0000_0000_0040},
    '{7'h39, 3'h0, 3'h1, 4'h0, 4'hd, 64'h0000_0000_0080_0001},
    '{7'h39, 3'h1, 3'h1, 4'hd, 4'hd, 64'hffff_ffff_ff80_0001},
    '{7'h39, 3'h2, 3'h1, 4'h0, 4'h5, 64'h4030_0000_0000_0005},
    '{7'h39, 3'h2, 3'h1, 4'h0, 4'he, 64'hc030_0000_0000_0005},
    '{7'h39, 3'h3, 3'h0, 4'h0, 4'h0, 64'h4030_c000_0000_0000},
    '{7'h39, 3'h4, 3'h0, 4'h0, 4'h0, 64'h4000_8000_0000_0000},
    '{7'h39, 3'h5, 3'h0, 4'h0, 4'h0, 64'h4001_8000_0000_0000},
    '{7'h39, 3'h6, 3'h0, 4'h0, 4'h0, 64'h4002_8000_0000_0000},
    '{7'h39, 3'h7, 3'h0, 4'h0, 4'h0, 64'h4003_8000_0000_0000},
    '{7'h39, 3'h0, 3'h0, 4'h0, 4'h0, 64'h0000_0000_0000_0001},
    '{7'h30, 3'h2, 3'h2, 4'h8, 4'h8, 64'h0000_0000_0000_0002}};
  // vector op that occupies each shared unit, and a scalar op it holds
  logic [6:0] vrows [4][2] = '{'{7'h78, 7'h32}, '{7'h70, 7'h34},
    '{7'h60, 7'h34}, '{7'h7c, 7'h38}};

  assign take = iss_valid & iss_ready;
  sfu_core i_dut (.clk(clk), .nrst(nrst), .iss_valid(iss_valid),
    .iss_op(iss_op), .iss_i(iss_i), .iss_j(iss_j), .iss_k(iss_k),
    .iss_ready(iss_ready), .scalar_src_first(scalar_src_first),
    .scalar_src_second(scalar_src_second),
    .address_src_reg(address_src_reg), .sreg_resv(sreg_resv),
    .areg_resv(areg_resv), .vec_issue(vec_issue), .vec_op(vec_op),
    .vector_length_count(vector_length_count), .res_valid(res_valid),
    .res_idx(res_idx), .res_data(res_data), .range_err(range_err));
  sfu_regs_model u_regs (.clk(clk), .nrst(nrst), .take(take),
    .iss_i(iss_i), .iss_j(iss_j), .iss_k(iss_k), .res_valid(res_valid),
    .res_idx(res_idx), .res_data(res_data),
    .scalar_src_first(scalar_src_first),
    .scalar_src_second(scalar_src_second), .sreg_resv(sreg_resv));

  // free-running 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [63:0] e, s);
    comparisons++;
    if (e !== s) begin
      $display("BAD %s expected %h seen %h", nm, e, s);
      num_errors++;
    end
  endtask

  // result latency per unit, from the package figures
  function automatic logic [3:0] lat_of(input logic [6:0] op);
    case (op)
      7'h30, 7'h31: return sfu_pkg::LAT_IADD;
      7'h32, 7'h33: return sfu_pkg::LAT_FADD;
      7'h38:        return sfu_pkg::LAT_RECIP;
      7'h39:        return sfu_pkg::LAT_XMIT;
      default:      return sfu_pkg::LAT_FMUL;
    endcase
  endfunction

  // present a request and wait, bounded, until it would be taken
  task automatic req(input logic [6:0] op, input logic [2:0] i, j, k,
                     input logic [63:0] va, vb, output int w);
    @(posedge clk);
    u_regs.sreg[j] <= va;
    u_regs.sreg[k] <= vb;
    iss_valid <= 1'b1;
    iss_op <= op;
    iss_i <= i;
    iss_j <= j;
    iss_k <= k;
    address_src_reg <= vb[23:0];
    vec_issue <= 1'b0;
    w = 0;
    do begin
      @(negedge clk);
      w++;
    end while (iss_ready !== 1'b1 && w < 40);
    if (w == 40) begin
      chk("issue wait", 64'h0, 64'h1);
      summarize();
    end
  endtask

  // take edge, then count cycles to the result and compare it
  task automatic get(input logic [2:0] i, input logic [3:0] lat,
                     input logic [63:0] mask, ex);
    int c;
    @(posedge clk);
    iss_valid <= 1'b0;
    c = 0;
    do begin
      @(negedge clk);
      c++;
    end while (res_valid !== 1'b1 && c < 20);
    chk("latency", 64'(lat), 64'(c));
    chk("result index", 64'(i), 64'(res_idx));
    chk("result data", ex, res_data & mask);
    rerr = range_err;
    // a result that never came ends the run at the closing report
    if (c == 20) begin
      summarize();
    end
  endtask

  initial begin
    {nrst, iss_valid, iss_op, iss_i, iss_j, iss_k} = '0;
    {address_src_reg, areg_resv, vec_issue, vec_op} = '0;
    vector_length_count = 7'h00;
    num_errors = 0;
    comparisons = 0;
    repeat (20) @(posedge clk);
    chk("valid in reset", 64'h0, 64'(res_valid));
    chk("data in reset", 64'h0, res_data);
    nrst <= 1'b1;
    // ordinary cases, one request at a time
    foreach (rows[r]) begin
      req(rows[r].op, 3'h7, rows[r].j, rows[r].k, pool[rows[r].a],
          pool[rows[r].b], n);
      get(3'h7, lat_of(rows[r].op), '1, rows[r].ex);
    end
    $display("test table done");
    // dependent pair back to back: second waits for the first
    req(sfu_pkg::OP_IADD, 3'h3, 3'h1, 3'h2, pool[8], pool[8], n);
    req(sfu_pkg::OP_IADD, 3'h4, 3'h3, 3'h3, pool[0], pool[0], n);
    chk("held on reserved source", 64'h1, 64'(n > 1));
    get(3'h4, sfu_pkg::LAT_IADD, '1, 64'h4);
    $display("test chained pair done");
    // refusals: unknown opcode, reserved address source, and a0 exempt
    @(posedge clk);
    iss_valid <= 1'b1;
    iss_op <= 7'h3a;
    iss_k <= 3'h2;
    areg_resv <= 8'h04;
    @(negedge clk);
    chk("unknown op ready", 64'h0, 64'(iss_ready));
    @(posedge clk);
    iss_op <= sfu_pkg::OP_XMIT;
    iss_j <= 3'h0;
    @(negedge clk);
    chk("reserved address ready", 64'h0, 64'(iss_ready));
    @(posedge clk);
    iss_k <= 3'h0;
    areg_resv <= 8'h01;
    @(negedge clk);
    chk("address zero ready", 64'h1, 64'(iss_ready));
    get(3'h4, sfu_pkg::LAT_XMIT, '1, 64'h1);
    $display("test refusals done");
    // shared units held for vector length plus four cycles
    foreach (vrows[v]) begin
      @(posedge clk);
      vec_issue <= 1'b1;
      vec_op <= vrows[v][0];
      vector_length_count <= 7'h02;
      req(vrows[v][1], 3'h7, 3'h1, 3'h2, pool[1], pool[1], n);
      chk("unit held cycles", 64'h7, 64'(n));
      get(3'h7, lat_of(vrows[v][1]), 64'h0000_0000_0003_ffff, 64'h0);
    end
    $display("test vector occupancy done");
    // reciprocal keeps sign, clears low bits; zero input flags range
    req(sfu_pkg::OP_RECIP, 3'h7, 3'h1, 3'h0, pool[15], pool[0], n);
    get(3'h7, sfu_pkg::LAT_RECIP, 64'h8000_0000_0003_ffff,
        64'h8000_0000_0000_0000);
    chk("no range error", 64'h0, 64'(rerr));
    req(sfu_pkg::OP_RECIP, 3'h7, 3'h0, 3'h0, pool[0], pool[0], n);
    get(3'h7, sfu_pkg::LAT_RECIP, 64'h0, 64'h0);
    chk("range error", 64'h1, 64'(rerr));
    $display("test reciprocal done");
    // reset in flight drops the pending result
    req(sfu_pkg::OP_FMUL, 3'h7, 3'h1, 3'h2, pool[1], pool[1], n);
    @(posedge clk);
    iss_valid <= 1'b0;
    nrst <= 1'b0;
    @(posedge clk);
    nrst <= 1'b1;
    n = 0;
    repeat (12) begin
      @(negedge clk);
      n += int'(res_valid !== 1'b0);
    end
    chk("valid after reset", 64'h0, 64'(n));
    $display("test mid-run reset done");
    summarize();
  end
endmodule
